// file: verilog/por_seq_pkg.sv
// Package for the power-up reset sequencer: register map, field layout,
// timing constants and the carrier struct shared by the sequencer files.
// Assumes a 125 MHz pclk and a 32-bit APB register bus.
package por_seq_pkg;

   // Clock and time figures
   localparam int unsigned CLK_HZ             = 125_000_000;
   localparam int unsigned DELAY_MS           = 72;
   localparam longint unsigned DELAY_CYCLES_L = (longint'(DELAY_MS) * CLK_HZ) / 1000;
   localparam logic [31:0] DELAY_CYCLES       = DELAY_CYCLES_L[31:0];
   localparam logic [10:0] OSC_WAIT_COUNT     = 11'h400;     // 1024 oscillator cycles
   localparam logic [31:0] POR_DETECT_CYCLES  = 32'h0000_0010; // Detect settling delay

   // Register byte addresses
   localparam logic [11:0] ADDR_PCS    = 12'h000;   // power_control_status
   localparam logic [11:0] ADDR_CONFIG = 12'h004;
   localparam logic [11:0] ADDR_STATE  = 12'h008;
   localparam logic [11:0] ADDR_IRQ_ST = 12'h00c;
   localparam logic [11:0] ADDR_IRQ_MK = 12'h010;

   // Field positions
   localparam int unsigned PCS_POR_BIT   = 1;
   localparam int unsigned CFG_PDD_BIT   = 0;   // powerup_delay_disable
   localparam int unsigned CFG_MODE_LSB  = 1;   // Two-bit oscillator mode
   localparam int unsigned IRQ_W         = 3;
   localparam int unsigned IRQ_DELAY_DONE = 0;
   localparam int unsigned IRQ_OSC_DONE   = 1;
   localparam int unsigned IRQ_RUN       = 2;

   // Oscillator modes
   typedef enum logic [1:0] {
      low_power_crystal_mode  = 2'h0,
      crystal_mode            = 2'h1,
      high_speed_crystal_mode = 2'h2,
      resistor_cap_osc_mode   = 2'h3
   } osc_mode_t;

   // Sequencer states, one-hot
   typedef enum logic [4:0] {
      ST_DETECT = 5'h01,
      ST_DELAY  = 5'h02,
      ST_OSC    = 5'h04,
      ST_HOLD   = 5'h08,
      ST_RUN    = 5'h10
   } seq_state_t;

   // Pin-side inputs that travel together
   typedef struct packed {
      logic supply_rise;        // Supply detector pulse
      logic master_clear_pin;   // Active-low external reset pin level
      logic wake_from_halt;     // Wake-up from low-power halt
      logic osc_edge;           // One-cycle strobe per oscillator_input_pin rising edge
      logic rc_tick;            // Internal RC oscillator tick
   } pin_in_t;

   localparam logic [31:0] RESET_CONFIG = 32'h0000_0000;

endpackage : por_seq_pkg

// file: verilog/por_seq_counter.sv
// Terminal counter used for every time-out stage of the sequencer.
// Assumes start and count_en come from the same pclk domain.
`timescale 1ns/100ps
module por_seq_counter #(
   parameter int unsigned W = 32
) (
   input  wire logic         pclk,      // Clock
   input  wire logic         presetn,   // Async reset, active low
   input  wire logic         start,     // Clear the count and arm
   input  wire logic         count_en,  // Count one step
   input  wire logic [W-1:0] limit,     // Terminal count
   output logic              done       // Level, high once terminal count is reached
);
   logic [W-1:0] count;
   logic         armed;

   // Count from zero after each start and stop at the limit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= '0;
         armed <= 1'b0;
         done  <= 1'b0;
      end else if (start) begin
         count <= '0;
         armed <= 1'b1;
         done  <= 1'b0;
      end else if (armed && count_en) begin
         if (count + W'(1) >= limit) begin
            armed <= 1'b0;
            done  <= 1'b1;
         end
         count <= count + W'(1);
      end
   end
endmodule : por_seq_counter

// file: verilog/por_seq.sv
// Power-up reset sequencer: power-on detect, power-up delay, oscillator
// start-up count, master-clear release, status flag and APB registers.
// Assumes pin inputs are synchronous to pclk and the oscillator edges
// arrive as one-cycle strobes.
`timescale 1ns/100ps
module por_seq (
   input  wire logic                  pclk,          // Clock
   input  wire logic                  presetn,       // Async reset, active low
   input  wire logic                  psel,          // APB select
   input  wire logic                  penable,       // APB enable
   input  wire logic                  pwrite,        // APB direction
   input  wire logic [11:0]           paddr,         // APB byte address
   input  wire logic [31:0]           pwdata,        // APB write data
   output logic      [31:0]           prdata,        // APB read data
   output logic                       pready,        // APB ready
   output logic                       pslverr,       // APB error
   input  wire por_seq_pkg::pin_in_t  pins,          // Pin-side inputs
   output logic                       core_reset_n,  // Core reset, active low
   output logic                       irq            // Level interrupt
);
   import por_seq_pkg::*;

   seq_state_t  state;
   seq_state_t  next_state;
   logic [31:0] config_reg;
   logic [7:0]  power_control_status;
   logic [IRQ_W-1:0] irq_status;
   logic [IRQ_W-1:0] irq_mask;
   logic        det_start;
   logic        det_done;
   logic        delay_start;
   logic        delay_done;
   logic        osc_start;
   logic        osc_done;
   logic        rd_clear;
   logic [IRQ_W-1:0] next_irq_status;
   logic        osc_crystal;
   logic        pdd;
   logic        por_event;
   logic        wr_en;
   logic        rd_en;
   logic        addr_ok;
   logic [IRQ_W-1:0] events;

   ////////////////////////////////////////////////////////////////////////
   // Configuration decode
   assign pdd         = config_reg[CFG_PDD_BIT];
   assign osc_crystal = (osc_mode_t'(config_reg[CFG_MODE_LSB +: 2]) != resistor_cap_osc_mode);
   assign por_event   = pins.supply_rise;

   // Stage counters
   por_seq_counter #(.W(32)) u_detect (
      .pclk     (pclk),
      .presetn  (presetn),
      .start    (det_start),
      .count_en (1'b1),
      .limit    (POR_DETECT_CYCLES),
      .done     (det_done)
   );

   // Power-up delay counts pclk cycles gated by the internal RC tick.
   // The tick is independent of the external oscillator, so this stage
   // can finish before the crystal has started at all.
   por_seq_counter #(.W(32)) u_delay (
      .pclk     (pclk),
      .presetn  (presetn),
      .start    (delay_start),
      .count_en (pins.rc_tick),
      .limit    (DELAY_CYCLES),
      .done     (delay_done)
   );

   // Oscillator start-up count on oscillator_input_pin edges.
   // Each start clears the count, so a wake-up never inherits a
   // partial count left over from an earlier run.
   por_seq_counter #(.W(11)) u_osc (
      .pclk     (pclk),
      .presetn  (presetn),
      .start    (osc_start),
      .count_en (pins.osc_edge),
      .limit    (OSC_WAIT_COUNT),
      .done     (osc_done)
   );

   ////////////////////////////////////////////////////////////////////////
   // Next state of the time-out sequence
   // A supply rise always wins: it restarts the whole sequence from the
   // detect stage, whatever stage was running, so a brown-out during a
   // count never lets the core out early.
   // Stage starts are one-cycle strobes raised on the transition into a
   // stage; the counters hold their done level until the next start.
   always_comb begin
      next_state  = state;
      det_start   = 1'b0;
      delay_start = 1'b0;
      osc_start   = 1'b0;
      if (por_event) begin
         next_state = ST_DETECT;
         det_start  = 1'b1;
      end else begin
         case (state)
            // Detect settling, then the delay stage unless disabled
            ST_DETECT: begin
               if (det_done) begin
                  if (!pdd) begin
                     next_state  = ST_DELAY;
                     delay_start = 1'b1;
                  end else if (osc_crystal) begin
                     next_state = ST_OSC;
                     osc_start  = 1'b1;
                  end else begin
                     next_state = ST_HOLD;
                  end
               end
            end
            // Power-up delay, then the oscillator count in crystal modes
            ST_DELAY: begin
               if (delay_done) begin
                  if (osc_crystal) begin
                     next_state = ST_OSC;
                     osc_start  = 1'b1;
                  end else begin
                     next_state = ST_HOLD;
                  end
               end
            end
            // Oscillator start-up count
            ST_OSC: begin
               if (osc_done) begin
                  next_state = ST_HOLD;
               end
            end
            // Time-outs over: only the pin level holds the core now
            ST_HOLD: begin
               if (pins.master_clear_pin) begin
                  next_state = ST_RUN;
               end
            end
            ST_RUN: begin
               if (!pins.master_clear_pin) begin
                  next_state = ST_HOLD;
               end else if (pins.wake_from_halt && osc_crystal) begin
                  next_state = ST_OSC;
                  osc_start  = 1'b1;
               end
            end
            default: begin
               next_state = ST_DETECT;
               det_start  = 1'b1;
            end
         endcase
      end
   end

   // State register; time-outs run whatever the master-clear level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_DETECT;
      end else begin
         state <= next_state;
      end
   end

   // Reset to the core held until running
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_reset_n <= 1'b0;
      end else begin
         core_reset_n <= (next_state == ST_RUN);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // APB decode: zero wait states
   assign wr_en   = psel && penable && pwrite;
   assign rd_en   = psel && penable && !pwrite;
   assign addr_ok = (paddr == ADDR_PCS) || (paddr == ADDR_CONFIG) || (paddr == ADDR_STATE)
                 || (paddr == ADDR_IRQ_ST) || (paddr == ADDR_IRQ_MK);

   // Power-on status flag: power-on reset clears, software sets
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_control_status <= 8'h00;
      end else if (por_event) begin
         power_control_status[PCS_POR_BIT] <= 1'b0;
      end else if (wr_en && paddr == ADDR_PCS) begin
         power_control_status <= pwdata[7:0];
      end
   end

   // Configuration register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         config_reg <= RESET_CONFIG;
      end else if (wr_en && paddr == ADDR_CONFIG) begin
         config_reg <= {29'h0, pwdata[2:0]};
      end
   end

   // Interrupt events: delay and oscillator stage ends and the release of the core
   assign events = {(next_state == ST_RUN) && (state != ST_RUN),
                    (state == ST_OSC) && osc_done,
                    (state == ST_DELAY) && delay_done};

   // Read clear drops only the bits that the read returned; the read data
   // was captured in the setup cycle, so an event landing there must
   // survive the clear in the access cycle. A new event always wins.
   assign rd_clear        = rd_en && (paddr == ADDR_IRQ_ST);
   assign next_irq_status = rd_clear ? ((irq_status & ~prdata[IRQ_W-1:0]) | events)
                                     : (irq_status | events);

   // Sticky interrupt status
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status <= '0;
      end else begin
         irq_status <= next_irq_status;
      end
   end

   // Interrupt mask
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask <= '0;
      end else if (wr_en && paddr == ADDR_IRQ_MK) begin
         irq_mask <= pwdata[IRQ_W-1:0];
      end
   end

   // Interrupt output from a flip-flop. It is computed from the next
   // status value, so it follows the status register with no extra lag:
   // a clearing read drops it at the same edge as the status bit.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(next_irq_status & irq_mask);
      end
   end

   // APB answer registers, one cycle access phase.
   // The answer is prepared in the setup cycle so that pready, prdata and
   // pslverr all come straight from flip-flops in the access cycle.
   // Unmapped addresses answer with pslverr and read as zero.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !addr_ok;
         prdata  <= 32'h0000_0000;
         if (psel && !penable && !pwrite) begin
            case (paddr)
               ADDR_PCS:    prdata <= {24'h0, power_control_status};
               ADDR_CONFIG: prdata <= config_reg;
               ADDR_STATE:  prdata <= {27'h0, state};
               ADDR_IRQ_ST: prdata <= {29'h0, irq_status};
               ADDR_IRQ_MK: prdata <= {29'h0, irq_mask};
               default:     prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

endmodule : por_seq

// file: verification/por_seq_assertions.sv
// Checker for the sequencer ports: APB answers, reset hold, interrupt.
// Bound to por_seq from the bench top; sees the top ports only.
`timescale 1ns/100ps
module por_seq_chk (
   input wire logic                 pclk,         // Clock
   input wire logic                 presetn,      // Reset, active low
   input wire logic                 psel,         // APB select
   input wire logic                 penable,      // APB enable
   input wire logic                 pwrite,       // APB direction
   input wire logic [11:0]          paddr,        // APB address
   input wire logic [31:0]          pwdata,       // APB write data
   input wire logic [31:0]          prdata,       // APB read data
   input wire logic                 pready,       // APB ready
   input wire logic                 pslverr,      // APB error
   input wire por_seq_pkg::pin_in_t pins,         // Pin inputs
   input wire logic                 core_reset_n, // Core reset
   input wire logic                 irq           // Interrupt
);
   import por_seq_pkg::*;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////
   // Bus answers, reset hold and interrupt clearing
   chk_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   chk_ready_in_access: assert property (pready |-> psel && penable)
      else $error("pready outside access phase");
   chk_err_unmapped: assert property (psel && !penable && paddr > ADDR_IRQ_MK |=> pslverr)
      else $error("unmapped access not refused");
   chk_err_reads_zero: assert property (pslverr |-> prdata == 32'h0)
      else $error("refused access returned data");
   chk_supply_holds_core: assert property (pins.supply_rise |=> !core_reset_n [*8])
      else $error("core left reset during detect");
   chk_pin_low_holds: assert property (!pins.master_clear_pin |=> !core_reset_n)
      else $error("core out of reset with pin low");
   chk_release_needs_pin: assert property ($rose(core_reset_n) |-> $past(pins.master_clear_pin))
      else $error("release without pin high");
   chk_irq_clear_access: assert property ($fell(irq) |-> $past(psel && penable))
      else $error("irq fell without register access");
endmodule : por_seq_chk

// file: verification/por_seq_pins_model.sv
// Model of the pin side: supply detector, master-clear pin, oscillator.
// Assumes the bench calls its tasks right after a rising pclk edge.
`timescale 1ns/100ps
module por_seq_pins_model (
   input wire logic            pclk, // Clock
   output por_seq_pkg::pin_in_t pins  // Pin inputs of the sequencer
);
   import por_seq_pkg::*;
   ////////////////////////////////////////
   // Internal RC tick runs every cycle, apart from the oscillator
   initial pins = '{rc_tick: 1'b1, default: 1'b0};
   // One-cycle pulses and pin level changes
   task automatic pulse_supply();
      @(posedge pclk) pins.supply_rise <= 1'b1;
      @(posedge pclk) pins.supply_rise <= 1'b0;
   endtask : pulse_supply
   task automatic pulse_wake();
      @(posedge pclk) pins.wake_from_halt <= 1'b1;
      @(posedge pclk) pins.wake_from_halt <= 1'b0;
   endtask : pulse_wake
   task automatic set_pin(input logic v);
      @(posedge pclk) pins.master_clear_pin <= v;
   endtask : set_pin
   // Oscillator edges with a chosen gap, fast or slow
   task automatic osc(input int n, input int gap);
      repeat (n) begin
         @(posedge pclk) pins.osc_edge <= 1'b1;
         @(posedge pclk) pins.osc_edge <= 1'b0;
         repeat (gap) @(posedge pclk);
      end
   endtask : osc
endmodule : por_seq_pins_model

// file: verification/por_seq_tb.sv
// Self-checking bench for the sequencer: APB tasks plus a pin model.
// Assumes the checker file and the pin model are compiled first.
`timescale 1ns/100ps
module por_seq_tb;
   import por_seq_pkg::*;
   logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, core_reset_n, irq;
   logic [11:0]         paddr;
   logic [31:0]         pwdata, prdata, r;
   pin_in_t             pins;
   int                  fails, total_checks, cyc, m;
   por_seq dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pins(pins), .core_reset_n(core_reset_n), .irq(irq));
   por_seq_pins_model pm_u (.pclk(pclk), .pins(pins));
   ////////////////////////////////////////
   // Clock, cycle ceiling and closing report
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         fails = fails + 1;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : report_and_stop
   // Comparison and APB transfer
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks = total_checks + 1;
      if (got !== exp) begin
         fails = fails + 1;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk) penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb
   ////////////////////////////////////////
   // Test sequence
   initial begin
      {psel, penable, pwrite, paddr, pwdata, fails, total_checks, cyc} = '0;
      presetn = 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      chk(core_reset_n, 1'b0);
      apb(0, ADDR_CONFIG, 0); chk(r, RESET_CONFIG);
      apb(0, ADDR_STATE, 0); chk(r, 32'h1);
      apb(1, 12'h020, 32'h5); chk(pslverr, 1'b1);
      apb(0, 12'h020, 0); chk(r, 32'h0);
      $display("test reset done");
      // Crystal mode, delay disabled, pin held low through the count
      apb(1, ADDR_CONFIG, 32'h3); apb(1, ADDR_IRQ_MK, 32'h2);
      pm_u.pulse_supply();
      repeat (24) @(posedge pclk);
      apb(0, ADDR_STATE, 0); chk(r, 32'h4);
      pm_u.osc(1023, 2);
      apb(0, ADDR_STATE, 0); chk(r, 32'h4);
      pm_u.osc(1, 0); repeat (4) @(posedge pclk);
      apb(0, ADDR_STATE, 0); chk(r, 32'h8);
      chk(core_reset_n, 1'b0); chk(irq, 1'b1);
      apb(0, ADDR_IRQ_ST, 0); chk(r & 32'h2, 32'h2);
      repeat (2) @(posedge pclk); chk(irq, 1'b0);
      pm_u.set_pin(1'b1); repeat (3) @(posedge pclk);
      chk(core_reset_n, 1'b1);
      apb(1, ADDR_IRQ_MK, 32'h4); repeat (2) @(posedge pclk); chk(irq, 1'b1);
      apb(0, ADDR_IRQ_ST, 0); repeat (2) @(posedge pclk); chk(irq, 1'b0);
      apb(0, ADDR_PCS, 0); chk(r & 32'h2, 32'h0);
      apb(1, ADDR_PCS, 32'h2);
      apb(0, ADDR_PCS, 0); chk(r, 32'h2);
      $display("test crystal power-up done");
      // Wake-up reruns the start-up count in each crystal mode only
      for (m = 0; m < 4; m++) begin
         apb(1, ADDR_CONFIG, {29'h0, m[1:0], 1'b1});
         pm_u.pulse_wake(); repeat (3) @(posedge pclk);
         chk(core_reset_n, m == 3);
         if (m < 3) pm_u.osc(1024, 1);
         repeat (4) @(posedge pclk); chk(core_reset_n, 1'b1);
      end
      apb(0, ADDR_PCS, 0); chk(r, 32'h2);
      $display("test wake done");
      // Delay enabled: the power-up delay stage follows detect and holds reset
      apb(1, ADDR_CONFIG, 32'h6); pm_u.pulse_supply(); repeat (24) @(posedge pclk);
      apb(0, ADDR_STATE, 0); chk(r, 32'h2);
      chk(core_reset_n, 1'b0);
      apb(1, ADDR_CONFIG, 32'h7);
      $display("test delay stage done");
      // RC mode with delay disabled leaves reset after detect alone
      pm_u.pulse_supply(); repeat (24) @(posedge pclk);
      chk(core_reset_n, 1'b1);
      apb(0, ADDR_PCS, 0); chk(r & 32'h2, 32'h0);
      $display("test rc power-up done");
      report_and_stop();
   end
endmodule : por_seq_tb
bind por_seq por_seq_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .pins(pins), .core_reset_n(core_reset_n), .irq(irq));
